// File: orpc_control.v
// recovery and pwm routing control register with output gating
`timescale 1ns/1ps
`include "orpc_defines.vh"
module orpc_control #(
  parameter EC_VARIANT = 1,
  parameter SLOW_CYCLES = `ORPC_SLOW_CYC,
  parameter FAST_CYCLES = `ORPC_FAST_CYC
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // register port
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire [15:0] regWrData,
  input wire regRdEn,
  output reg [15:0] regRdData_ff,
  // mode and companion control bits
  input wire activeMode,
  input wire recoveryRateSelect,
  input wire [3:0] halfbridgeEnable,
  input wire mirrorFeedbackEnable,
  input wire [5:0] dacCode,
  // pwm sources
  input wire pwmInputOne,
  input wire pwmInputTwo,
  input wire internalPwmRaw,
  // overcurrent events and flag clears
  input wire [4:0] overcurrentEvent,
  input wire [4:0] overcurrentFlagClear,
  input wire globalFaultClear,
  // outputs
  output reg [3:0] halfbridgeDrive_ff,
  output reg mirrorFeedbackDrive_ff,
  output reg [4:0] perOutputOvercurrentFlag_ff,
  output reg globalFaultSummaryFlag_ff,
  output reg internalPwmGeneratorEnable_ff,
  output reg internalPwmGate_ff,
  output reg pwmInputTwoGate_ff,
  output reg dacFullScaleSelect_ff,
  output reg [5:0] dacCodeOut_ff
);
  localparam [15:0] WR_MASK = (EC_VARIANT != 0) ? `ORPC_MASK_EC : `ORPC_MASK_BASE;

  reg [15:0] ctrl_ff;
  reg [4:0] outputOff_ff;
  reg [15:0] nxt_ctrl;
  reg [4:0] nxt_outputOff;
  reg [4:0] nxt_perOutputOvercurrentFlag;
  reg nxt_globalFaultSummaryFlag;
  reg [3:0] nxt_halfbridgeDrive;
  reg nxt_mirrorFeedbackDrive;
  wire [4:0] recoveryEnable;
  wire [3:0] halfbridgePwmSelect;
  wire [4:0] recoveryDone;
  wire [4:0] timerStart;
  wire clearAll;

  // ****************************************
  // field decode
  // ****************************************
  assign recoveryEnable = {ctrl_ff[`ORPC_BIT_RECFB], ctrl_ff[`ORPC_BIT_REC4],
                           ctrl_ff[`ORPC_BIT_REC3], ctrl_ff[`ORPC_BIT_REC2],
                           ctrl_ff[`ORPC_BIT_REC1]};
  assign halfbridgePwmSelect = {ctrl_ff[`ORPC_BIT_SEL4], ctrl_ff[`ORPC_BIT_SEL3],
                                ctrl_ff[`ORPC_BIT_SEL2], ctrl_ff[`ORPC_BIT_SEL1]};
  assign clearAll = ~activeMode;

  // clamp to the highest code not above 1.2 V when full scale is not selected
  function [5:0] clampCode;
    input [5:0] code;
    input fullScale;
    begin
      if (!fullScale && code > `ORPC_DAC_CLAMP)
        clampCode = `ORPC_DAC_CLAMP;
      else
        clampCode = code;
    end
  endfunction

  // ****************************************
  // register write and read
  // ****************************************
  always @*
  begin
    nxt_ctrl = ctrl_ff;
    if (clearAll)
      nxt_ctrl = `ORPC_RESET_CTRL;
    else if (regWrEn && regAddr == `ORPC_ADDR_CTRL)
      nxt_ctrl = regWrData & WR_MASK;
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_ff <= `ORPC_RESET_CTRL;
      regRdData_ff <= 16'h0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      if (regRdEn)
        regRdData_ff <= (regAddr == `ORPC_ADDR_CTRL) ? ctrl_ff : 16'h0000;
    end
  end

  // ****************************************
  // overcurrent shutdown and recovery
  // ****************************************
  assign timerStart = overcurrentEvent & ~{5{clearAll}};

  // a new event reloads the timer of its channel
  genvar ch;
  generate
    for (ch = 0; ch < 5; ch = ch + 1)
    begin : gRecovery
      orpc_recovery_timer #(
        .CW(32),
        .SLOW_CYCLES(SLOW_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
      ) uTimer (
        .clock(clock),
        .rstn(rstn),
        .clear(clearAll),
        .start(timerStart[ch]),
        .fast(recoveryRateSelect),
        .done_ff(recoveryDone[ch])
      );
    end
  endgenerate

  // event wins over recovery and over clear
  always @*
  begin
    nxt_outputOff = overcurrentEvent
                  | (outputOff_ff & ~(recoveryDone & recoveryEnable));
    nxt_perOutputOvercurrentFlag = overcurrentEvent
                  | (perOutputOvercurrentFlag_ff & ~overcurrentFlagClear);
    nxt_globalFaultSummaryFlag = (|overcurrentEvent)
                  | (globalFaultSummaryFlag_ff & ~globalFaultClear);
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      outputOff_ff <= 5'h00;
      perOutputOvercurrentFlag_ff <= 5'h00;
      globalFaultSummaryFlag_ff <= 1'b0;
    end
    else if (clearAll)
    begin
      outputOff_ff <= 5'h00;
      perOutputOvercurrentFlag_ff <= 5'h00;
      globalFaultSummaryFlag_ff <= 1'b0;
    end
    else
    begin
      outputOff_ff <= nxt_outputOff;
      perOutputOvercurrentFlag_ff <= nxt_perOutputOvercurrentFlag;
      globalFaultSummaryFlag_ff <= nxt_globalFaultSummaryFlag;
    end
  end

  // ****************************************
  // output gating and pwm routing
  // ****************************************
  always @*
  begin
    // only the first pwm pin gates half-bridges
    nxt_halfbridgeDrive = halfbridgeEnable & ~outputOff_ff[3:0]
                        & (~halfbridgePwmSelect | {4{pwmInputOne}});
    nxt_mirrorFeedbackDrive = mirrorFeedbackEnable & ~outputOff_ff[4];
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      halfbridgeDrive_ff <= 4'h0;
      mirrorFeedbackDrive_ff <= 1'b0;
      internalPwmGeneratorEnable_ff <= 1'b0;
      internalPwmGate_ff <= 1'b0;
      pwmInputTwoGate_ff <= 1'b0;
      dacFullScaleSelect_ff <= 1'b0;
      dacCodeOut_ff <= 6'h00;
    end
    else if (clearAll)
    begin
      halfbridgeDrive_ff <= 4'h0;
      mirrorFeedbackDrive_ff <= 1'b0;
      internalPwmGeneratorEnable_ff <= 1'b0;
      internalPwmGate_ff <= 1'b0;
      pwmInputTwoGate_ff <= 1'b0;
      dacFullScaleSelect_ff <= 1'b0;
      dacCodeOut_ff <= 6'h00;
    end
    else
    begin
      halfbridgeDrive_ff <= nxt_halfbridgeDrive;
      mirrorFeedbackDrive_ff <= nxt_mirrorFeedbackDrive;
      internalPwmGeneratorEnable_ff <= ctrl_ff[`ORPC_BIT_INTERNAL_PWM_GENERATOR_ENABLE];
      internalPwmGate_ff <= ctrl_ff[`ORPC_BIT_INTERNAL_PWM_GENERATOR_ENABLE] & internalPwmRaw;
      pwmInputTwoGate_ff <= pwmInputTwo;
      dacFullScaleSelect_ff <= ctrl_ff[`ORPC_BIT_FSR];
      dacCodeOut_ff <= clampCode(dacCode, ctrl_ff[`ORPC_BIT_FSR]);
    end
  end
endmodule // orpc_control

// File: orpc_control_properties.sv
// assertions on the control register ports
`timescale 1ns/1ps
module orpc_control_properties (
  // watched ports
  input wire clock,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire [15:0] regWrData,
  input wire regRdEn,
  input wire [15:0] regRdData_ff,
  input wire activeMode,
  input wire pwmInputOne,
  input wire [4:0] overcurrentEvent,
  input wire [3:0] halfbridgeDrive_ff,
  input wire [4:0] perOutputOvercurrentFlag_ff,
  input wire globalFaultSummaryFlag_ff,
  input wire internalPwmGeneratorEnable_ff,
  input wire internalPwmGate_ff,
  input wire [5:0] dacCodeOut_ff,
  input wire dacFullScaleSelect_ff
);
  reg [15:0] ctl_ff;
  wire wrHit = regWrEn && regAddr == 8'h02 && activeMode;
  // shadow of the register
  always @(posedge clock or negedge rstn)
    if (!rstn) ctl_ff <= 16'h0000;
    else if (!activeMode) ctl_ff <= 16'h0000;
    else if (wrHit) ctl_ff <= regWrData;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence ocHit; overcurrentEvent[0] && activeMode; endsequence
  sequence wrHeld; wrHit ##1 activeMode; endsequence
  chk_write_visible: assert property (wrHeld |=>
    internalPwmGeneratorEnable_ff == $past(regWrData[8], 2)) else $error("copy wrong");
  chk_read_unmapped: assert property (regRdEn && regAddr != 8'h02 |=>
    regRdData_ff == 16'h0000) else $error("unmapped read");
  chk_unused_zero: assert property (regRdEn |=>
    (regRdData_ff & ~16'hE7E5) == 16'h0000) else $error("unused bits");
  chk_oc_flags: assert property (ocHit |=>
    perOutputOvercurrentFlag_ff[0] && globalFaultSummaryFlag_ff) else $error("flags");
  chk_oc_off: assert property (ocHit |=> ##1 !halfbridgeDrive_ff[0])
    else $error("output on");
  chk_pwm_gate: assert property (ctl_ff[7] && !pwmInputOne |=>
    !halfbridgeDrive_ff[0]) else $error("gate");
  chk_internal_pwm_generator_enable_off: assert property (!ctl_ff[8] |=> !internalPwmGate_ff)
    else $error("internal_pwm_generator_enable");
  chk_dac_clamp: assert property (!dacFullScaleSelect_ff |->
    dacCodeOut_ff <= 6'h33) else $error("clamp");
  chk_standby_clear: assert property (!activeMode [*2] |=>
    halfbridgeDrive_ff == 4'h0 && perOutputOvercurrentFlag_ff == 5'h00) else $error("standby");
endmodule // orpc_control_properties
bind orpc_control orpc_control_properties i_orpc_control_properties (
  .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData_ff(regRdData_ff), .activeMode(activeMode),
  .pwmInputOne(pwmInputOne), .overcurrentEvent(overcurrentEvent),
  .halfbridgeDrive_ff(halfbridgeDrive_ff),
  .perOutputOvercurrentFlag_ff(perOutputOvercurrentFlag_ff),
  .globalFaultSummaryFlag_ff(globalFaultSummaryFlag_ff),
  .internalPwmGeneratorEnable_ff(internalPwmGeneratorEnable_ff),
  .internalPwmGate_ff(internalPwmGate_ff), .dacCodeOut_ff(dacCodeOut_ff),
  .dacFullScaleSelect_ff(dacFullScaleSelect_ff));

// File: orpc_defines.vh
// constants for the recovery and pwm routing control register
`ifndef ORPC_DEFINES_VH
`define ORPC_DEFINES_VH
// ****************************************
// register map
// ****************************************
`define ORPC_ADDR_CTRL 8'h02
`define ORPC_RESET_CTRL 16'h0000
`define ORPC_MASK_EC 16'hE7E5
`define ORPC_MASK_BASE 16'hE5E4
// ****************************************
// field positions
// ****************************************
`define ORPC_BIT_REC1 15
`define ORPC_BIT_REC2 14
`define ORPC_BIT_REC3 13
`define ORPC_BIT_REC4 10
`define ORPC_BIT_RECFB 9
`define ORPC_BIT_INTERNAL_PWM_GENERATOR_ENABLE 8
`define ORPC_BIT_SEL1 7
`define ORPC_BIT_SEL2 6
`define ORPC_BIT_SEL3 5
`define ORPC_BIT_SEL4 2
`define ORPC_BIT_FSR 0
// ****************************************
// dac clamp: 1.5 V / 64 per step, 1.2 V is code 51
// ****************************************
`define ORPC_DAC_CLAMP 6'h33
// ****************************************
// timing
// ****************************************
`define ORPC_CLK_MHZ 250
`define ORPC_SLOW_NS 50000
`define ORPC_FAST_NS 4000
`define ORPC_SLOW_CYC ((`ORPC_SLOW_NS * `ORPC_CLK_MHZ + 999) / 1000)
`define ORPC_FAST_CYC ((`ORPC_FAST_NS * `ORPC_CLK_MHZ + 999) / 1000)
`endif

// File: orpc_host_model.sv
// host model driving the register port
`timescale 1ns/1ps
module orpc_host_model (
  // register port
  input wire clock,
  output reg [7:0] regAddr,
  output reg regWrEn,
  output reg [15:0] regWrData,
  output reg regRdEn,
  input wire [15:0] regRdData_ff
);
  initial {regAddr, regWrEn, regWrData, regRdEn} = 26'h0;
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clock) #1;
      {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
      @(posedge clock) #1;
      {regWrData, regWrEn} = {~d, 1'b0};
    end
  endtask
  task rd(input [7:0] a, output [15:0] q);
    begin
      @(posedge clock) #1;
      {regAddr, regRdEn} = {a, 1'b1};
      @(posedge clock) #1;
      regRdEn = 1'b0;
      q = regRdData_ff;
    end
  endtask
endmodule // orpc_host_model

// File: orpc_recovery_timer.v
// recovery delay counter for one output channel
`timescale 1ns/1ps
module orpc_recovery_timer #(
  parameter CW = 16,
  parameter SLOW_CYCLES = 12500,
  parameter FAST_CYCLES = 1000
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // control
  input wire clear,
  input wire start,
  input wire fast,
  // status
  output reg done_ff
);
  reg [CW-1:0] count_ff;
  reg busy_ff;
  reg [CW-1:0] nxt_count;
  reg nxt_busy;
  reg nxt_done;

  always @*
  begin
    nxt_count = count_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (clear)
    begin
      nxt_count = {CW{1'b0}};
      nxt_busy = 1'b0;
    end
    else if (start)
    begin
      // delay length latched at the event
      nxt_count = fast ? FAST_CYCLES[CW-1:0] : SLOW_CYCLES[CW-1:0];
      nxt_busy = 1'b1;
    end
    else if (busy_ff)
    begin
      if (count_ff <= {{(CW-1){1'b0}}, 1'b1})
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
      else
      begin
        nxt_count = count_ff - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      count_ff <= {CW{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end
endmodule // orpc_recovery_timer

// File: test_orpc_control.sv
// self-checking bench for the control register
`timescale 1ns/1ps
module test_orpc_control;
  reg clock, rstn, activeMode, rate, pwmOne, pwmTwo, pwmRaw, mfEn, gClr;
  reg [3:0] hbEn;
  reg [4:0] ocClr;
  reg [5:0] dac;
  reg [4:0] oc;
  reg [15:0] q;
  wire [7:0] regAddr;
  wire regWrEn, regRdEn, gFlag, pwmiEn, pwmiGate, dac_full_scale_select, mfDrive, pwmTwoGate;
  wire [15:0] regWrData, rdData;
  wire [3:0] drive;
  wire [4:0] ocFlag;
  wire [5:0] dacOut;
  integer errors = 0, n_tests = 0, expReg = 0, i, n;
  localparam SLOW_SIM = 20;
  localparam FAST_SIM = 5;
  initial begin clock = 0; forever #2 clock = ~clock; end
  orpc_host_model i_orpc_host_model (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(rdData));
  orpc_control #(.SLOW_CYCLES(SLOW_SIM), .FAST_CYCLES(FAST_SIM)) i_orpc_control (.clock(clock),
    .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData_ff(rdData), .activeMode(activeMode), .recoveryRateSelect(rate),
    .halfbridgeEnable(hbEn), .mirrorFeedbackEnable(mfEn), .dacCode(dac), .pwmInputOne(pwmOne),
    .pwmInputTwo(pwmTwo), .internalPwmRaw(pwmRaw), .overcurrentEvent(oc),
    .overcurrentFlagClear(ocClr), .globalFaultClear(gClr), .halfbridgeDrive_ff(drive),
    .mirrorFeedbackDrive_ff(mfDrive), .perOutputOvercurrentFlag_ff(ocFlag),
    .globalFaultSummaryFlag_ff(gFlag), .internalPwmGeneratorEnable_ff(pwmiEn),
    .internalPwmGate_ff(pwmiGate), .pwmInputTwoGate_ff(pwmTwoGate), .dacFullScaleSelect_ff(dac_full_scale_select),
    .dacCodeOut_ff(dacOut));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin errors = errors + 1; $display("mismatch %0t: %h not %h", $time, seen, exp); end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wrm(input [15:0] v);
    begin i_orpc_host_model.wr(8'h02, v); expReg = v & 16'hE7E5; end
  endtask
  task rdc;
    begin i_orpc_host_model.rd(8'h02, q); check(q, expReg[15:0]); end
  endtask
  initial begin
    {rstn, activeMode, rate, pwmOne, pwmTwo, pwmRaw, hbEn, dac, oc, mfEn, ocClr, gClr} = 0;
    q = $urandom(76551);
    repeat (2) @(posedge clock);
    #1 {rstn, activeMode} = 2'b11;
    rdc;
    for (i = 0; i < 8; i = i + 1) begin wrm($urandom); rdc; end
    @(posedge clock) #1 rstn = 0;
    @(posedge clock) #1 rstn = 1;
    expReg = 0;
    rdc;
    i_orpc_host_model.rd(8'h05, q);
    check(q, 16'h0000);
    wrm(16'h01E4);
    {hbEn, mfEn} = 5'h1F;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clock) #1 {pwmOne, pwmTwo, pwmRaw} = {i[1:0], i[0]};
      @(posedge clock) #1 check(drive, {4{pwmOne}});
      check(pwmiGate, pwmRaw);
      check(pwmTwoGate, pwmTwo);
      check(pwmiEn, 1'b1);
    end
    dac = 6'h3F;
    for (i = 0; i < 2; i = i + 1) begin
      wrm(i);
      repeat (2) @(posedge clock);
      #1 check(dacOut, i ? 6'h3F : 6'h33);
      check(dac_full_scale_select, i);
      check({pwmiEn, pwmiGate}, 2'h0);
    end
    for (i = 0; i < 3; i = i + 1) begin
      rate = i[0];
      wrm(i < 2 ? 16'h8200 : 16'h0000);
      @(posedge clock) #1 {ocClr, gClr} = 6'h3F;
      @(posedge clock) #1 {ocClr, gClr} = 6'h00;
      check({ocFlag[0], ocFlag[4], gFlag}, 3'h0);
      oc = 5'h11;
      if (i == 2) {ocClr, gClr} = 6'h23;
      @(posedge clock) #1 {oc, ocClr, gClr} = 11'h000;
      check({ocFlag[0], ocFlag[4], gFlag}, 3'h7);
      @(posedge clock) #1 check({drive[0], mfDrive}, 2'h0);
      n = 0;
      while (drive[0] !== 1'b1 && n < 60) begin @(posedge clock) #1 n = n + 1; end
      check(n < 60, i < 2);
      check(mfDrive, i < 2);
      if (i < 2) check(n, (i ? FAST_SIM : SLOW_SIM) + 1);
    end
    @(posedge clock) #1 activeMode = 0;
    repeat (2) @(posedge clock);
    #1 check({drive, mfDrive, ocFlag, gFlag}, 11'h000);
    activeMode = 1;
    expReg = 0;
    rdc;
    stop_test;
  end
endmodule // test_orpc_control
